// ### rtl/xcvr_ctrl_top.sv
// Clock, reset, power-down and reconfiguration control of a transceiver.
// Assumes fabric pins are asynchronous; registers sit on AXI4-Lite.
// Functional notes
// - PLL reset held means the PLL stays in reset and never locks.
// - After PLL reset release the PLL locks to its selected references.
// - An output shows whether the PLL has lock.
// - With PFD feedback one reference per TX channel, then one per RX.
// - Without PFD feedback reference 0 feeds all TX and 1 all RX.
// - Bonded modes get one fabric interface clock output.
// - Power-down turns off PCS, serial interface, CDR and PCIe logic.
// - Power-down leaves the reference clock buffers on.
// - TX digital reset holds the TX coding logic in reset.
// - RX analogue reset resets the RX PMA analogue circuitry.
// - RX digital reset holds the RX coding logic in reset.
// - Reconfig clock times reconfiguration and non-PIPE offset cancel.
// - Controller drives the inbound bus; status returns outbound.
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module xcvr_ctrl_top
   import xcvr_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [xcvr_ctrl_pkg::AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [xcvr_ctrl_pkg::AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [xcvr_ctrl_pkg::NUM_REF-1:0] pll_ref_clk,
   input wire logic pll_reset_pin,
   output logic pll_locked,
   output logic pll_hold,
   input wire logic xcvr_powerdown_pin,
   output logic pcs_pwr_off,
   output logic high_speed_serial_interface_pwr_off,
   output logic cdr_pwr_off,
   output logic pcie_pwr_off,
   output logic refclk_buf_en,
   input wire logic tx_pcs_reset_pin,
   input wire logic rx_pma_reset_pin,
   input wire logic rx_pcs_reset_pin,
   output logic tx_pcs_rst,
   output logic rx_pma_rst,
   output logic rx_pcs_rst,
   output logic core_clk_out,
   input wire logic reconfig_clk,
   input wire logic [xcvr_ctrl_pkg::RCFG_W-1:0] reconfig_to_xcvr,
   output logic [xcvr_ctrl_pkg::RCFG_W-1:0] reconfig_from_xcvr,
   output logic offset_cancel_busy
);
   import xcvr_ctrl_pkg::*;
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_s1_ff;
   logic [PIN_W-1:0] pin_s2_ff;
   logic rck_d_ff;
   logic rcfg_tick;
   logic [31:0] ctrl_ff;
   logic [31:0] cfg_ff;
   logic [2:0] err_ff;
   logic [2:0] err_set;
   logic [2:0] err_clr;
   logic aw_hold_ff;
   logic w_hold_ff;
   logic [AW-1:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic wr_go;
   logic wr_hit;
   logic [31:0] wr_val;
   logic [31:0] rd_val;
   logic rd_hit;
   logic [31:0] stat_word;
   logic pll_hold_ff;
   logic pll_locked_ff;
   logic pwr_off_ff;
   logic tx_rst_ff;
   logic rxa_rst_ff;
   logic rxd_rst_ff;
   logic core_clk_ff;
   logic [NUM_REF-1:0] mon_locked;
   logic [NUM_REF-1:0] sel_mask;
   logic sel_ok;
   logic [3:0] nch2;
   logic cfg_pfd;
   logic cfg_bond;
   logic cfg_pipe;
   oc_state_e oc_ff;
   oc_state_e nxt_oc;
   logic [CNT_W-1:0] oc_cnt_ff;
   logic [RCFG_W-1:0] rcfg_out_ff;
   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   assign pin_raw = {reconfig_to_xcvr, reconfig_clk, rx_pcs_reset_pin,
                     rx_pma_reset_pin, tx_pcs_reset_pin,
                     xcvr_powerdown_pin, pll_reset_pin};
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
         rck_d_ff <= 1'b0;
      end
      else
      begin
         pin_s1_ff <= pin_raw;
         pin_s2_ff <= pin_s1_ff;
         rck_d_ff <= pin_s2_ff[PIN_RCK];
      end
   end
   assign rcfg_tick = pin_s2_ff[PIN_RCK] && !rck_d_ff;
   // ***********************************************
   // AXI4-Lite write channel
   // ***********************************************
   assign awready = !aw_hold_ff && !bvalid_ff;
   assign wready = !w_hold_ff && !bvalid_ff;
   assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign wr_hit = (awaddr_ff == CTRL_OFF) || (awaddr_ff == STAT_OFF) ||
                   (awaddr_ff == ERR_OFF) || (awaddr_ff == CFG_OFF);
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   always_comb
   begin
      wr_val = '0;
      for (int b = 0; b < 4; b++)
         wr_val[8*b +: 8] = wstrb_ff[b] ? wdata_ff[8*b +: 8] : 8'h00;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
      end
      else if (wr_go)
      begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_hold_ff <= 1'b1;
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
         end
      end
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
         bvalid_ff <= 1'b0;
   end
   // ***********************************************
   // Control, config and error registers
   // ***********************************************
   // Unstrobed bytes keep their value
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl_ff <= CTRL_RST;
      else if (wr_go && awaddr_ff == CTRL_OFF)
         ctrl_ff <= ((ctrl_ff & ~strb_mask(wstrb_ff)) | wr_val) & CTRL_MASK;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cfg_ff <= CFG_RST;
      else if (wr_go && awaddr_ff == CFG_OFF)
         cfg_ff <= ((cfg_ff & ~strb_mask(wstrb_ff)) | wr_val) & CFG_MASK;
   end
   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      logic [31:0] m;
      m = '0;
      for (int b = 0; b < 4; b++)
         m[8*b +: 8] = {8{s[b]}};
      return m;
   endfunction : strb_mask
   assign err_clr = (wr_go && awaddr_ff == ERR_OFF) ? wr_val[2:0] : 3'b000;
   // Set beats clear so a short pulse in the clear cycle is kept
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         err_ff <= '0;
      else
         err_ff <= (err_ff & ~err_clr) | err_set;
   end
   assign cfg_pfd = cfg_ff[PFD_BIT];
   assign cfg_bond = cfg_ff[BOND_BIT];
   assign cfg_pipe = cfg_ff[PIPE_BIT];
   // ***********************************************
   // Reset pulse width checks
   // ***********************************************
   for (genvar g = 0; g < 3; g++)
   begin : g_pw
      logic [1:0] cnt_ff;
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            cnt_ff <= '0;
         else if (pin_s2_ff[PIN_TX+g])
            cnt_ff <= (cnt_ff == 2'(RSTPW_CYC)) ? cnt_ff : cnt_ff + 2'd1;
         else
            cnt_ff <= '0;
      end
      assign err_set[g] = !pin_s2_ff[PIN_TX+g] && cnt_ff != 2'd0 &&
                          cnt_ff < 2'(RSTPW_CYC);
   end
   // ***********************************************
   // AXI4-Lite read channel
   // ***********************************************
   assign stat_word = {23'h0, oc_ff, pwr_off_ff, rxd_rst_ff, rxa_rst_ff,
                       tx_rst_ff, pll_hold_ff, pll_locked_ff};
   always_comb
   begin
      rd_hit = 1'b1;
      unique case (araddr)
         CTRL_OFF: rd_val = ctrl_ff;
         STAT_OFF: rd_val = stat_word;
         ERR_OFF: rd_val = {29'h0, err_ff};
         CFG_OFF: rd_val = cfg_ff;
         default:
         begin
            rd_val = '0;
            rd_hit = 1'b0;
         end
      endcase
   end
   assign arready = !rvalid_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_val;
         rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready)
         rvalid_ff <= 1'b0;
   end
   // ***********************************************
   // Power-down and reset holds
   // ***********************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pwr_off_ff <= 1'b1;
         tx_rst_ff <= 1'b1;
         rxa_rst_ff <= 1'b1;
         rxd_rst_ff <= 1'b1;
         pll_hold_ff <= 1'b1;
      end
      else
      begin
         pwr_off_ff <= pin_s2_ff[PIN_PWR] || ctrl_ff[PWRDN_BIT];
         tx_rst_ff <= pin_s2_ff[PIN_TX] || ctrl_ff[TXRST_BIT];
         rxa_rst_ff <= pin_s2_ff[PIN_TX+1] || ctrl_ff[RXARST_BIT];
         rxd_rst_ff <= pin_s2_ff[PIN_TX+2] || ctrl_ff[RXDRST_BIT];
         pll_hold_ff <= pin_s2_ff[PIN_PLL] || ctrl_ff[PLLRST_BIT];
      end
   end
   assign pcs_pwr_off = pwr_off_ff;
   assign high_speed_serial_interface_pwr_off = pwr_off_ff;
   assign cdr_pwr_off = pwr_off_ff;
   assign pcie_pwr_off = pwr_off_ff;
   // Buffers stay up so references survive power-down
   assign refclk_buf_en = 1'b1;
   assign tx_pcs_rst = tx_rst_ff;
   assign rx_pma_rst = rxa_rst_ff;
   assign rx_pcs_rst = rxd_rst_ff;
   assign pll_hold = pll_hold_ff;
   // ***********************************************
   // Reference selection and lock
   // ***********************************************
   assign nch2 = {cfg_ff[CH_LSB +: CH_W], 1'b0};
   always_comb
   begin
      for (int i = 0; i < NUM_REF; i++)
         sel_mask[i] = cfg_pfd ? (4'(i) < nch2) : (i < 2);
   end
   for (genvar r = 0; r < NUM_REF; r++)
   begin : g_ref
      ref_activity_mon u_mon (
         .aclk(aclk),
         .aresetn(aresetn),
         .hold(pll_hold_ff),
         .ref_pin(pll_ref_clk[r]),
         .locked(mon_locked[r])
      );
   end
   assign sel_ok = &(mon_locked | ~sel_mask);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pll_locked_ff <= 1'b0;
      else
         pll_locked_ff <= !pll_hold_ff && sel_ok;
   end
   assign pll_locked = pll_locked_ff;
   // Interface clock runs at aclk/2, only once locked
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         core_clk_ff <= 1'b0;
      else
         core_clk_ff <= (cfg_bond && pll_locked_ff) && !core_clk_ff;
   end
   assign core_clk_out = core_clk_ff;
   // ***********************************************
   // Offset cancellation and reconfiguration
   // ***********************************************
   always_comb
   begin
      nxt_oc = oc_ff;
      unique case (oc_ff)
         OC_IDLE:
            if (!cfg_pipe && !rxa_rst_ff && pll_locked_ff)
               nxt_oc = OC_RUN;
         OC_RUN:
            if (rcfg_tick && oc_cnt_ff == CNT_W'(OC_TICKS - 1))
               nxt_oc = OC_DONE;
         OC_DONE:
            nxt_oc = OC_DONE;
         default:
            nxt_oc = OC_IDLE;
      endcase
      if (cfg_pipe || rxa_rst_ff || pwr_off_ff)
         nxt_oc = OC_IDLE;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         oc_ff <= OC_IDLE;
         oc_cnt_ff <= '0;
      end
      else
      begin
         oc_ff <= nxt_oc;
         if (nxt_oc != OC_RUN)
            oc_cnt_ff <= '0;
         else if (rcfg_tick)
            oc_cnt_ff <= oc_cnt_ff + CNT_W'(1);
      end
   end
   assign offset_cancel_busy = (oc_ff == OC_RUN);
   // Outbound status moves only on reconfig clock edges
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rcfg_out_ff <= '0;
      else if (rcfg_tick)
         rcfg_out_ff <= {^pin_s2_ff[PIN_RTO +: RCFG_W], oc_ff == OC_DONE,
                         oc_ff == OC_RUN, pll_locked_ff};
   end
   assign reconfig_from_xcvr = rcfg_out_ff;
   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   hold_no_lock_a: assert property (pll_hold_ff |=> !pll_locked)
      else $error("lock seen while PLL held");
   lock_cause_a: assert property ($rose(pll_locked) |-> $past(sel_ok))
      else $error("lock rose without references");
   lock_drop_a: assert property (!sel_ok |=> !pll_locked)
      else $error("lock kept with missing reference");
   relock_low_a: assert property ($fell(pll_hold_ff) |-> !pll_locked[*4])
      else $error("lock too soon after release");
   pfd_sel_a: assert property (cfg_pfd |->
      sel_mask == 8'((16'h1 << nch2) - 16'h1))
      else $error("pfd mask wrong");
   nopfd_sel_a: assert property (!cfg_pfd |-> sel_mask == 8'h03)
      else $error("non-pfd mask wrong");
   bond_clk_a: assert property (cfg_bond && pll_locked |=>
      core_clk_out != $past(core_clk_out))
      else $error("bonded clock stalled");
   pwr_down_a: assert property (xcvr_powerdown_pin[*3] |=>
      pcs_pwr_off && cdr_pwr_off && pcie_pwr_off)
      else $error("power-down not applied");
   refclk_on_a: assert property (pcs_pwr_off |-> refclk_buf_en)
      else $error("refclk buffer off");
   tx_hold_a: assert property (tx_pcs_reset_pin[*3] |=> tx_pcs_rst)
      else $error("tx reset missed");
   rxa_hold_a: assert property (rx_pma_reset_pin[*3] |=> rx_pma_rst)
      else $error("rx pma reset missed");
   rxd_hold_a: assert property (rx_pcs_reset_pin[*3] |=> rx_pcs_rst)
      else $error("rx pcs reset missed");
   oc_pipe_a: assert property (cfg_pipe |=> !offset_cancel_busy)
      else $error("offset cancel in pipe mode");
   rcfg_stable_a: assert property (!rcfg_tick |=>
      $stable(reconfig_from_xcvr))
      else $error("outbound bus moved off tick");
   lock_rise_c: cover property ($rose(pll_locked));
   oc_done_c: cover property (oc_ff == OC_RUN ##1 oc_ff == OC_DONE);
   short_pw_c: cover property (|err_set);
   bond_c: cover property (cfg_bond && core_clk_out);
endmodule : xcvr_ctrl_top
`default_nettype wire

// ### rtl/xcvr_ctrl_pkg.sv
// Constants for the transceiver clock, reset and power control block.
// Assumes a single 25 MHz bus clock and an AXI4-Lite master.
`default_nettype none
package xcvr_ctrl_pkg;
   // ***********************************************
   // Sizes
   // ***********************************************
   localparam int NUM_CH = 4;
   localparam int NUM_REF = 2 * NUM_CH;
   localparam int AW = 8;
   localparam int CNT_W = 5;
   // ***********************************************
   // Register offsets and reset values
   // ***********************************************
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STAT_OFF = 8'h04;
   localparam logic [7:0] ERR_OFF = 8'h08;
   localparam logic [7:0] CFG_OFF = 8'h0c;
   localparam logic [31:0] CTRL_RST = 32'h0000_001d;
   localparam logic [31:0] CTRL_MASK = 32'h0000_001f;
   localparam logic [31:0] CFG_RST = 32'h0000_0040;
   localparam logic [31:0] CFG_MASK = 32'h0000_0077;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Control and config register fields
   localparam int PLLRST_BIT = 0;
   localparam int PWRDN_BIT = 1;
   localparam int TXRST_BIT = 2;
   localparam int RXARST_BIT = 3;
   localparam int RXDRST_BIT = 4;
   localparam int PFD_BIT = 0;
   localparam int BOND_BIT = 1;
   localparam int PIPE_BIT = 2;
   localparam int CH_LSB = 4;
   localparam int CH_W = 3;
   // ***********************************************
   // Pin synchroniser layout
   // ***********************************************
   localparam int PIN_PLL = 0;
   localparam int PIN_PWR = 1;
   localparam int PIN_TX = 2;
   localparam int PIN_RCK = 5;
   localparam int PIN_RTO = 6;
   localparam int RCFG_W = 4;
   localparam int PIN_W = 10;
   // ***********************************************
   // Timing counts: bus clock cycles, reference edges and reconfig ticks
   // ***********************************************
   localparam int RSTPW_CYC = 2;
   localparam int LOCK_EDGES = 8;
   localparam int LOSS_CYC = 16;
   localparam int OC_TICKS = 16;
   typedef enum logic [2:0] {
      OC_IDLE = 3'b001,
      OC_RUN = 3'b010,
      OC_DONE = 3'b100
   } oc_state_e;
endpackage : xcvr_ctrl_pkg
`default_nettype wire

// ### rtl/ref_activity_mon.sv
// Reference clock activity monitor, one per reference input.
// Assumes the reference pin is asynchronous to aclk and slower than aclk/2.
`timescale 1ns/1ps
`default_nettype none
module ref_activity_mon
   import xcvr_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic hold,
   input wire logic ref_pin,
   output logic locked
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic [CNT_W-1:0] edges_ff;
   logic [CNT_W-1:0] quiet_ff;
   logic seen;
   assign seen = s2_ff ^ s3_ff;
   assign locked = (edges_ff == CNT_W'(LOCK_EDGES));
   // ***********************************************
   // Synchroniser
   // ***********************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end
      else
      begin
         s1_ff <= ref_pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   // ***********************************************
   // Lock acquisition and loss
   // ***********************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn || hold)
      begin
         edges_ff <= '0;
         quiet_ff <= '0;
      end
      else if (seen)
      begin
         quiet_ff <= '0;
         if (!locked)
            edges_ff <= edges_ff + CNT_W'(1);
      end
      else if (quiet_ff == CNT_W'(LOSS_CYC))
         edges_ff <= '0;
      else
         quiet_ff <= quiet_ff + CNT_W'(1);
   end
endmodule : ref_activity_mon
`default_nettype wire

// ### bench/fabric_model.sv
// Fabric model: reference clocks and reconfiguration controller.
// Assumes the bench clock aclk; outputs change after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module fabric_model
   import xcvr_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic [xcvr_ctrl_pkg::NUM_REF-1:0] ref_en,
   input wire logic [xcvr_ctrl_pkg::RCFG_W-1:0] rcfg_word,
   output logic [xcvr_ctrl_pkg::NUM_REF-1:0] pll_ref_clk,
   output logic reconfig_clk,
   output logic [xcvr_ctrl_pkg::RCFG_W-1:0] reconfig_to_xcvr
);
   logic [2:0] div_ff = 3'h0;
   initial
   begin
      pll_ref_clk = '0;
      reconfig_to_xcvr = '0;
   end
   // Stopped references stand low, never frozen high
   always @(posedge aclk)
   begin
      div_ff <= div_ff + 3'h1;
      if (div_ff[1:0] == 2'h3)
         pll_ref_clk <= ~pll_ref_clk & ref_en;
      reconfig_to_xcvr <= rcfg_word;
   end
   assign reconfig_clk = div_ff[2];
endmodule : fabric_model
`default_nettype wire

// ### bench/transceiver_clock_reset_power_ctrl_tb_top.sv
// Bench for the transceiver clock, reset and power control block.
// Assumes the fabric model file; AXI4-Lite master tasks live here.
`timescale 1ns/1ps
`default_nettype none
module transceiver_clock_reset_power_ctrl_tb_top;
   import xcvr_ctrl_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [AW-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, pll_reset_pin = 1'b0;
   logic xcvr_powerdown_pin = 1'b0;
   logic [31:0] wdata = '0, rdata, rd;
   logic [3:0] wstrb = 4'hf, rcfg_word = '0, reconfig_from_xcvr;
   logic [NUM_REF-1:0] ref_en = '0;
   logic [1:0] bresp, rresp, resp;
   logic [2:0] rst_pins = '0;
   logic awready, wready, bvalid, arready, rvalid, pll_locked, pll_hold;
   logic refclk_buf_en, core_clk_out, offset_cancel_busy, prev, hi;
   wire logic [3:0] pwr_offs;
   wire logic [2:0] rst_outs;
   wire logic [NUM_REF-1:0] pll_ref_clk;
   wire logic reconfig_clk;
   wire logic [RCFG_W-1:0] reconfig_to_xcvr;
   int mismatches = 0, samples_checked = 0;

   xcvr_ctrl_top i_xcvr_ctrl_top (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .pll_ref_clk, .pll_reset_pin, .pll_locked,
      .pll_hold, .xcvr_powerdown_pin, .pcs_pwr_off(pwr_offs[0]),
      .high_speed_serial_interface_pwr_off(pwr_offs[1]),
      .cdr_pwr_off(pwr_offs[2]), .pcie_pwr_off(pwr_offs[3]), .refclk_buf_en,
      .tx_pcs_reset_pin(rst_pins[0]), .rx_pma_reset_pin(rst_pins[1]),
      .rx_pcs_reset_pin(rst_pins[2]), .tx_pcs_rst(rst_outs[0]),
      .rx_pma_rst(rst_outs[1]), .rx_pcs_rst(rst_outs[2]), .core_clk_out,
      .reconfig_clk, .reconfig_to_xcvr, .reconfig_from_xcvr,
      .offset_cancel_busy);
   fabric_model i_fabric_model (.aclk, .ref_en, .rcfg_word, .pll_ref_clk,
      .reconfig_clk, .reconfig_to_xcvr);

   // ****************************************
   // Checking and bus tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      k = 0;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
         k++;
      end
      while (bvalid !== 1'b1 && k < 100);
      resp = bresp;
      bready <= 1'b0;
      chk("write answered", k < 100, 1);
   endtask : wr

   task automatic rd_reg(input logic [7:0] a);
      int k;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      k = 0;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
         k++;
      end
      while (rvalid !== 1'b1 && k < 100);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      chk("read answered", k < 100, 1);
   endtask : rd_reg

   // Bounded wait, then the lock level must match
   task automatic wait_lock(input logic v);
      for (int k = 0; k < 400 && pll_locked !== v; k++)
         @(posedge aclk);
      chk("pll_locked", pll_locked, v);
   endtask : wait_lock

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      @(posedge aclk);
      chk("pll_hold", pll_hold, 1);
      chk("pll_locked", pll_locked, 0);
      chk("resets", rst_outs, 3'h7);
      chk("refclk_buf_en", refclk_buf_en, 1);
      rd_reg(CTRL_OFF);
      chk("ctrl", rd, CTRL_RST);
      rd_reg(CFG_OFF);
      chk("cfg", rd, CFG_RST);
      rd_reg(8'h10);
      chk("bad read resp", resp, RESP_SLVERR);
      chk("bad read data", rd, 32'h0);
      wr(8'h10, 32'h1);
      chk("bad write", resp, RESP_SLVERR);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_lock;
      ref_en <= 8'h03;
      wr(CTRL_OFF, 32'h0);
      chk("write ok", resp, RESP_OKAY);
      wait_lock(1'b1);
      rd_reg(STAT_OFF);
      chk("stat lock", rd[0], 1);
      ref_en <= 8'h01;
      wait_lock(1'b0);
      ref_en <= 8'h03;
      wait_lock(1'b1);
      pll_reset_pin <= 1'b1;
      // Two sync flops, hold flop, then the lock flop
      repeat (4) @(posedge aclk);
      hi = 1'b0;
      repeat (64)
      begin
         @(posedge aclk);
         hi = hi | pll_locked;
      end
      chk("lock in reset", hi, 0);
      chk("pll_hold", pll_hold, 1);
      pll_reset_pin <= 1'b0;
      wait_lock(1'b1);
      $display("t_lock done");
   endtask : t_lock

   task automatic t_pfd;
      wr(CFG_OFF, 32'h21);
      wait_lock(1'b0);
      ref_en <= 8'h0f;
      wait_lock(1'b1);
      ref_en <= 8'h03;
      wr(CFG_OFF, CFG_RST);
      wait_lock(1'b1);
      $display("t_pfd done");
   endtask : t_pfd

   task automatic t_power;
      xcvr_powerdown_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("pwr off", pwr_offs, 4'hf);
      chk("refclk buf", refclk_buf_en, 1);
      xcvr_powerdown_pin <= 1'b0;
      repeat (4) @(posedge aclk);
      chk("pwr on", pwr_offs, 4'h0);
      $display("t_power done");
   endtask : t_power

   task automatic t_resets;
      @(posedge aclk);
      for (int i = 0; i < 3; i++)
      begin
         rst_pins[i] <= 1'b1;
         repeat (2) @(posedge aclk);
         rst_pins[i] <= 1'b0;
         repeat (2) @(posedge aclk);
         chk("reset out", rst_outs, 3'h1 << i);
         repeat (4) @(posedge aclk);
      end
      rd_reg(ERR_OFF);
      chk("no short pulse", rd, 0);
      // One-cycle pulse on purpose, to trip the width check
      rst_pins[2] <= 1'b1;
      @(posedge aclk);
      rst_pins[2] <= 1'b0;
      repeat (4) @(posedge aclk);
      rd_reg(ERR_OFF);
      chk("short pulse", rd, 32'h4);
      wr(ERR_OFF, 32'h4);
      rd_reg(ERR_OFF);
      chk("flag cleared", rd, 32'h0);
      $display("t_resets done");
   endtask : t_resets

   task automatic t_bond;
      wr(CFG_OFF, 32'h42);
      repeat (2) @(posedge aclk);
      prev = core_clk_out;
      @(posedge aclk);
      chk("core clk toggles", core_clk_out ^ prev, 1);
      wr(CFG_OFF, CFG_RST);
      repeat (3) @(posedge aclk);
      chk("core clk idle", core_clk_out, 0);
      $display("t_bond done");
   endtask : t_bond

   task automatic t_ocal(input logic [31:0] cfg, input logic busy);
      wr(CFG_OFF, cfg);
      wr(CTRL_OFF, 32'h08);
      wr(CTRL_OFF, 32'h0);
      hi = 1'b0;
      // Restart through an RX analogue reset; power-down and PIPE mode also send it to idle
      for (int k = 0; k < 200 && offset_cancel_busy !== 1'b0 || k < 60; k++)
      begin
         @(posedge aclk);
         hi = hi | offset_cancel_busy;
      end
      chk("oc ran", hi, busy);
      rd_reg(STAT_OFF);
      chk("oc state", rd[8:6], busy ? 3'h4 : 3'h1);
      rcfg_word <= 4'h7;
      repeat (40) @(posedge aclk);
      chk("to controller", reconfig_from_xcvr, {1'b1, busy, 2'b01});
      $display("t_ocal done");
   endtask : t_ocal

   task automatic complete_run;
      $display("Checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   always #20 aclk = ~aclk;

   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_lock();
      t_pfd();
      t_power();
      t_resets();
      t_bond();
      t_ocal(CFG_RST, 1'b1);
      rcfg_word <= 4'h0;
      t_ocal(32'h44, 1'b0);
      complete_run();
   end

   // Tests need some 700 cycles; allow far more
   initial
   begin
      #(40 * 20000);
      mismatches++;
      complete_run();
   end
endmodule : transceiver_clock_reset_power_ctrl_tb_top
`default_nettype wire
